/* hw/size_resolver_pkg.sv */
// Shared constants for the operand, address and stack size resolver
package size_resolver_pkg;

    // ==========================================================
    // Operating modes
    typedef enum logic [1:0] {
        MODE_REAL,
        MODE_PROT,
        MODE_V86,
        MODE_SYSTEM_MANAGEMENT
    } opmode_e;

    // ==========================================================
    // Register bus layout
    localparam int WB_ADR_W = 4;
    localparam int WB_DAT_W = 32;
    localparam logic [WB_ADR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [WB_ADR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [WB_ADR_W-1:0] REG_COUNT = 4'h8;
    localparam logic [WB_ADR_W-1:0] REG_OVRCOUNT = 4'hC;

    // Control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic CTRL_EN_RST = 1'b1;

    // Status fields
    localparam int ST_OP32_BIT = 0;
    localparam int ST_AD32_BIT = 1;
    localparam int ST_WSP_BIT = 2;
    localparam int ST_XFER32_BIT = 3;
    localparam int ST_FRAME32_BIT = 4;
    localparam int ST_OFSOK_BIT = 5;
    localparam int ST_W = 6;

    // ==========================================================
    // Offset widths and bounds
    localparam int OFS_W = 32;
    localparam int NARROW_W = 16;
    localparam logic [OFS_W-1:0] TOP_NARROW = 32'h0000FFFF;
    localparam logic [OFS_W-1:0] TOP_WIDE = 32'hFFFFFFFF;
    localparam logic [OFS_W-1:0] ZERO_WORD = 32'h00000000;
    localparam logic [OFS_W-1:0] ONE_WORD = 32'h00000001;

endpackage

/* hw/offset_former.sv */
// Cuts an effective offset to the resolved address width
module offset_former #(
    parameter int FULL_W = 32,
    parameter int NARROW_W = 16
) (
    input wire logic wideAddr, // Resolved address size is the wide one
    input wire logic [FULL_W-1:0] rawOffset, // Offset from address generation
    output logic [FULL_W-1:0] effOffset // Offset as the segment sees it
);

    // ==========================================================
    // Width selection
    // A narrow offset wraps inside the first window of the segment,
    // whatever limit the descriptor carries
    wire logic [FULL_W-1:0] narrowOffset;
    assign narrowOffset = {{(FULL_W-NARROW_W){1'b0}}, rawOffset[NARROW_W-1:0]};
    assign effOffset = wideAddr ? rawOffset : narrowOffset;

endmodule

/* hw/operand_address_size_resolver.sv */
// Per-instruction operand, address and stack size resolver with Wishbone registers
//
// Operation
// [RL1] Code segment default flag set gives 32-bit sizes, clear gives 16-bit.
// [RL2] Real and virtual-8086 modes default to 16-bit operand and address sizes.
// [RL3] Operand-size prefix flips the default operand size for that instruction.
// [RL4] Address-size prefix flips the default address size for that instruction.
// [RL5] Prefix effect lasts one instruction; the next reverts to the default.
// [RL6] Both prefixes work in real, protected and virtual-8086 modes.
// [RL7] Operand and address sizes resolve independently; all four pairs reachable.
// [RL8] Gate transfers take size and return frame from gate type only.
// [RL9] Stack-size flag picks wide or narrow stack pointer for implicit references.
// [RL10] Explicit stack references use the instruction's effective address size.
// [RL11] Expand-down data segments take their upper bound from the stack-size flag.
// [RL12] Effective offset is 16 bits wide for narrow, 32 bits for wide addressing.
// [RL13] Narrow addressing reaches only the first 64 KBytes of any segment.
// [RL14] Resolved sizes leave as one registered result with a valid pulse.
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
module operand_address_size_resolver
    import size_resolver_pkg::*;
(
    input wire logic sys_clk, // Core clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [size_resolver_pkg::WB_ADR_W-1:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lane selects
    input wire logic [size_resolver_pkg::WB_DAT_W-1:0] wb_dat_i, // Write data
    output logic [size_resolver_pkg::WB_DAT_W-1:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic instValid, // Decoded instruction present
    input wire size_resolver_pkg::opmode_e opMode, // Processor operating mode
    input wire logic codeDefault32, // Default-size flag of code segment
    input wire logic stackBig, // Stack-size flag of stack segment
    input wire logic opPrefix, // Operand-size prefix seen
    input wire logic adPrefix, // Address-size prefix seen
    input wire logic gateXfer, // Transfer goes through a gate
    input wire logic gate32, // Gate is of the wide type
    input wire logic implicitStack, // Implicit stack reference
    input wire logic [size_resolver_pkg::OFS_W-1:0] rawOffset, // Raw offset
    input wire logic dataExpandDown, // Data segment is expand-down
    input wire logic dataBig, // Stack-size flag of the data segment
    input wire logic [size_resolver_pkg::OFS_W-1:0] segLimit, // Segment limit
    output logic resValid, // Result valid, one-cycle pulse
    output logic opSize32, // Operand size is 32 bits
    output logic addrSize32, // Address size is 32 bits
    output logic wideStackPtr, // Use wide_stack_pointer, else narrow
    output logic xferSize32, // Transfer operand size is 32 bits
    output logic frame32, // Return frame saved in wide format
    output logic [size_resolver_pkg::OFS_W-1:0] effOffset, // Effective offset
    output logic [size_resolver_pkg::OFS_W-1:0] expandTop, // Upper offset bound
    output logic offsetOk // Offset lies inside the segment
);
    import size_resolver_pkg::*;

    // ==========================================================
    // Register state
    logic enable_ff;
    logic ack_ff;
    logic [WB_DAT_W-1:0] count_ff;
    logic [WB_DAT_W-1:0] ovrCount_ff;
    logic [ST_W-1:0] status_ff;

    // ==========================================================
    // Result state
    logic valid_ff;
    logic op32_ff;
    logic ad32_ff;
    logic wsp_ff;
    logic xfer32_ff;
    logic frame32_ff;
    logic [OFS_W-1:0] ofs_ff;
    logic [OFS_W-1:0] top_ff;
    logic ofsOk_ff;

    // ==========================================================
    // Size resolution
    wire logic acceptInst;
    wire logic segmentMode;
    wire logic defaultWide;
    wire logic nxt_op32;
    wire logic nxt_ad32;
    wire logic nxt_wsp;
    wire logic nxt_xfer32;
    wire logic nxt_frame32;
    wire logic [OFS_W-1:0] nxt_ofs;
    wire logic [OFS_W-1:0] nxt_top;
    wire logic nxt_ofsOk;
    wire logic inUpRange;
    wire logic inDownRange;

    assign acceptInst = instValid & enable_ff;

    // Only protected mode reads descriptors; the other modes are native narrow
    assign segmentMode = (opMode == MODE_PROT);
    assign defaultWide = segmentMode & codeDefault32; // RL1 RL2

    // Each prefix flips its own size alone, in every mode
    assign nxt_op32 = defaultWide ^ opPrefix; // RL3 RL6 RL7
    assign nxt_ad32 = defaultWide ^ adPrefix; // RL4 RL6 RL7

    // A gate decides the transfer size; prefix and code flag are ignored
    assign nxt_xfer32 = gateXfer ? gate32 : nxt_op32; // RL8
    assign nxt_frame32 = gateXfer ? gate32 : nxt_op32; // RL8

    // Stack flag for implicit pushes and pops, address size otherwise
    assign nxt_wsp = implicitStack ? stackBig : nxt_ad32; // RL9 RL10

    offset_former #(
        .FULL_W(OFS_W),
        .NARROW_W(NARROW_W)
    ) i_offset_former (
        .wideAddr(nxt_ad32), // RL12 RL13
        .rawOffset(rawOffset),
        .effOffset(nxt_ofs)
    );

    // Expand-down bound follows the data segment's own size flag
    assign nxt_top = dataBig ? TOP_WIDE : TOP_NARROW; // RL11
    assign inDownRange = (nxt_ofs > segLimit) && (nxt_ofs <= nxt_top); // RL11
    assign inUpRange = (nxt_ofs <= segLimit);
    assign nxt_ofsOk = dataExpandDown ? inDownRange : inUpRange;

    // ==========================================================
    // Result registers
    // No prefix state is kept between instructions, so an override
    // cannot leak into the next one
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= acceptInst; // RL14
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            op32_ff <= 1'b0;
            ad32_ff <= 1'b0;
            wsp_ff <= 1'b0;
            xfer32_ff <= 1'b0;
            frame32_ff <= 1'b0;
        end else if (acceptInst) begin
            op32_ff <= nxt_op32; // RL5 RL14
            ad32_ff <= nxt_ad32; // RL5 RL14
            wsp_ff <= nxt_wsp;
            xfer32_ff <= nxt_xfer32;
            frame32_ff <= nxt_frame32;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ofs_ff <= ZERO_WORD;
            top_ff <= TOP_NARROW;
            ofsOk_ff <= 1'b0;
        end else if (acceptInst) begin
            ofs_ff <= nxt_ofs;
            top_ff <= nxt_top;
            ofsOk_ff <= nxt_ofsOk;
        end
    end

    assign resValid = valid_ff;
    assign opSize32 = op32_ff;
    assign addrSize32 = ad32_ff;
    assign wideStackPtr = wsp_ff;
    assign xferSize32 = xfer32_ff;
    assign frame32 = frame32_ff;
    assign effOffset = ofs_ff;
    assign expandTop = top_ff;
    assign offsetOk = ofsOk_ff;

    // ==========================================================
    // Wishbone slave
    // Every access is answered one cycle after the strobe; unmapped
    // addresses read zero and ignore writes
    wire logic wbReq;
    wire logic wbWrite;
    wire logic selCtrl;
    wire logic selStatus;
    wire logic selCount;
    wire logic selOvr;
    wire logic ctrlWrite;
    wire logic clearCounts;
    wire logic anyPrefix;
    wire logic [WB_DAT_W-1:0] ctrlWord;
    wire logic [WB_DAT_W-1:0] statusWord;
    wire logic [WB_DAT_W-1:0] nxt_dat;
    wire logic [ST_W-1:0] nxt_status;

    assign wbReq = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wbWrite = wbReq & wb_we_i;
    assign selCtrl = (wb_adr_i == REG_CTRL);
    assign selStatus = (wb_adr_i == REG_STATUS);
    assign selCount = (wb_adr_i == REG_COUNT);
    assign selOvr = (wb_adr_i == REG_OVRCOUNT);
    assign ctrlWrite = wbWrite & selCtrl & wb_sel_i[0];
    assign clearCounts = ctrlWrite & wb_dat_i[CTRL_CLR_BIT];
    assign anyPrefix = opPrefix | adPrefix;

    assign ctrlWord = {{(WB_DAT_W-1){1'b0}}, enable_ff};
    assign statusWord = {{(WB_DAT_W-ST_W){1'b0}}, status_ff};
    assign nxt_dat = selCtrl ? ctrlWord :
                     selStatus ? statusWord :
                     selCount ? count_ff :
                     selOvr ? ovrCount_ff : ZERO_WORD;

    assign nxt_status = {nxt_ofsOk, nxt_frame32, nxt_xfer32,
                         nxt_wsp, nxt_ad32, nxt_op32};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
            wb_dat_o <= ZERO_WORD;
        end else begin
            ack_ff <= wbReq;
            wb_dat_o <= wbReq ? nxt_dat : ZERO_WORD;
        end
    end

    assign wb_ack_o = ack_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            enable_ff <= CTRL_EN_RST;
        end else if (ctrlWrite) begin
            enable_ff <= wb_dat_i[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            status_ff <= '0;
        end else if (acceptInst) begin
            status_ff <= nxt_status;
        end
    end

    // A count that lands in the clearing cycle survives as one
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count_ff <= ZERO_WORD;
        end else if (clearCounts) begin
            count_ff <= acceptInst ? ONE_WORD : ZERO_WORD;
        end else if (acceptInst) begin
            count_ff <= count_ff + ONE_WORD;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ovrCount_ff <= ZERO_WORD;
        end else if (clearCounts) begin
            ovrCount_ff <= (acceptInst & anyPrefix) ? ONE_WORD : ZERO_WORD;
        end else if (acceptInst & anyPrefix) begin
            ovrCount_ff <= ovrCount_ff + ONE_WORD;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    a_default_size: assert property ( // RL1
        acceptInst && segmentMode && !opPrefix && !adPrefix
        |=> opSize32 == $past(codeDefault32) && addrSize32 == $past(codeDefault32))
        else $error("Default size does not follow code flag");

    a_native_narrow: assert property ( // RL2
        acceptInst && !segmentMode && !opPrefix && !adPrefix
        |=> !opSize32 && !addrSize32)
        else $error("Native mode did not give narrow sizes");

    a_operand_flip: assert property ( // RL3
        acceptInst && opPrefix |=> opSize32 != $past(defaultWide))
        else $error("Operand prefix did not flip size");

    a_address_flip: assert property ( // RL4
        acceptInst && adPrefix |=> addrSize32 != $past(defaultWide))
        else $error("Address prefix did not flip size");

    a_prefix_once: assert property ( // RL5
        acceptInst && opPrefix ##1 acceptInst && !opPrefix
        |=> opSize32 == $past(defaultWide))
        else $error("Operand override leaked to next instruction");

    a_both_prefix: assert property ( // RL7
        acceptInst && opPrefix && adPrefix && segmentMode
        |=> opSize32 == !$past(codeDefault32) && addrSize32 == !$past(codeDefault32))
        else $error("Double prefix did not give a matching pair");

    // Native modes have a narrow default, so both prefixes must give the wide pair
    a_native_prefix: assert property ( // RL6
        acceptInst && !segmentMode && opPrefix && adPrefix |=> opSize32 && addrSize32)
        else $error("Native mode prefixes did not give wide sizes");

    a_gate_size: assert property ( // RL8
        acceptInst && gateXfer
        |=> xferSize32 == $past(gate32) && frame32 == $past(gate32))
        else $error("Gate transfer size not from gate type");

    a_stack_pick: assert property ( // RL9
        acceptInst && implicitStack |=> wideStackPtr == $past(stackBig))
        else $error("Implicit stack pointer not from stack flag");

    a_explicit_stack: assert property ( // RL10
        acceptInst && !implicitStack |=> wideStackPtr == addrSize32)
        else $error("Explicit stack width not from address size");

    a_expand_top: assert property ( // RL11
        acceptInst && dataExpandDown
        |=> expandTop == ($past(dataBig) ? TOP_WIDE : TOP_NARROW))
        else $error("Expand-down bound not from size flag");

    // A wide offset past the narrow window can never lie in a narrow expand-down segment
    a_down_narrow: assert property ( // RL11
        acceptInst && dataExpandDown && !dataBig && nxt_ad32 && rawOffset > TOP_NARROW
        |=> !offsetOk)
        else $error("Expand-down offset beyond narrow bound accepted");

    a_narrow_offset: assert property ( // RL13
        resValid && !addrSize32 |-> effOffset <= TOP_NARROW)
        else $error("Narrow offset beyond first window");

    a_narrow_cut: assert property ( // RL13
        acceptInst && !nxt_ad32
        |=> effOffset[OFS_W-1:NARROW_W] == '0
            && effOffset[NARROW_W-1:0] == $past(rawOffset[NARROW_W-1:0]))
        else $error("Narrow offset not cut to the low half");

    a_wide_offset: assert property ( // RL12
        acceptInst && nxt_ad32 |=> effOffset == $past(rawOffset))
        else $error("Wide offset was cut");

    a_result_pulse: assert property ( // RL14
        acceptInst |=> resValid ##1 (resValid == $past(acceptInst)))
        else $error("Result valid does not track accepted instruction");

    a_refused_idle: assert property ( // RL14
        instValid && !enable_ff |=> !resValid && $stable(opSize32) && $stable(effOffset))
        else $error("Refused instruction changed the result");

    a_bus_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Bus request not answered next cycle");

endmodule

/* bench/inst_source.sv */
// Instruction source standing in for fetch, prefix decode and descriptor logic
module inst_source (
    input wire logic sys_clk, // Core clock
    input wire logic resetn, // Reset, active low
    input wire logic issue, // Present an instruction next cycle
    input wire logic [10:0] fields, // Mode and flag bits
    input wire logic [31:0] rawIn, // Offset to present
    input wire logic [31:0] limitIn, // Limit to present
    output logic instValid, // Instruction present
    output size_resolver_pkg::opmode_e opMode, // Operating mode
    output logic codeDefault32, // Code default flag
    output logic stackBig, // Stack size flag
    output logic opPrefix, // Operand prefix
    output logic adPrefix, // Address prefix
    output logic gateXfer, // Gate transfer
    output logic gate32, // Wide gate
    output logic implicitStack, // Implicit stack access
    output logic dataExpandDown, // Expand-down data
    output logic dataBig, // Data big flag
    output logic [31:0] rawOffset, // Offset out
    output logic [31:0] segLimit // Limit out
);
    timeunit 1ns;
    timeprecision 1ns;
    import size_resolver_pkg::*;
    logic [10:0] drv;
    logic [63:0] words;
    // ======================================
    // Lines toggle between instructions, so a stale value is never mistaken for a live one
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            instValid <= 1'h0;
            drv <= 11'h000;
            words <= 64'h0;
        end else if (issue) begin
            instValid <= 1'h1;
            drv <= fields;
            words <= {rawIn, limitIn};
        end else begin
            instValid <= 1'h0;
            drv <= ~drv;
            words <= ~words;
        end
    end
    assign opMode = opmode_e'(drv[10:9]);
    assign {codeDefault32, stackBig, opPrefix, adPrefix, gateXfer} = drv[8:4];
    assign {gate32, implicitStack, dataExpandDown, dataBig} = drv[3:0];
    assign {rawOffset, segLimit} = words;
endmodule

/* bench/test_operand_address_size_resolver.sv */
// Self-checking bench for the operand, address and stack size resolver
module test_operand_address_size_resolver;
    timeunit 1ns;
    timeprecision 1ns;
    import size_resolver_pkg::*;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, issue = 1'h0;
    logic [WB_ADR_W-1:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, rawR = 32'h0, limR = 32'h0;
    logic [31:0] wb_dat_o, expandTop, effOffset, rawOffset, segLimit;
    logic wb_ack_o, instValid, codeDefault32, stackBig, opPrefix, adPrefix, gateXfer;
    logic gate32, implicitStack, dataExpandDown, dataBig, resValid, opSize32, addrSize32;
    logic wideStackPtr, xferSize32, frame32, offsetOk;
    opmode_e opMode;
    logic [10:0] fld = 11'h000;
    logic [5:0] lastF = 6'h00;
    logic [5:0] expF[$];
    logic [31:0] expO[$], expT[$];
    int mismatches = 0, n_compared = 0, nSent = 0, nPref = 0;
    wire [5:0] gotF = {offsetOk, frame32, xferSize32, wideStackPtr, addrSize32, opSize32};

    always #20 sys_clk = ~sys_clk;

    operand_address_size_resolver i_operand_address_size_resolver (.sys_clk, .resetn,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .instValid, .opMode, .codeDefault32, .stackBig, .opPrefix, .adPrefix, .gateXfer,
        .gate32, .implicitStack, .rawOffset, .dataExpandDown, .dataBig, .segLimit, .resValid,
        .opSize32, .addrSize32, .wideStackPtr, .xferSize32, .frame32, .effOffset, .expandTop,
        .offsetOk);
    inst_source i_inst_source (.sys_clk, .resetn, .issue, .fields(fld), .rawIn(rawR),
        .limitIn(limR), .instValid, .opMode, .codeDefault32, .stackBig, .opPrefix, .adPrefix,
        .gateXfer, .gate32, .implicitStack, .dataExpandDown, .dataBig, .rawOffset, .segLimit);

    // ======================================
    // Compare and bus tasks
    task automatic complete_run;
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flags(input logic [5:0] got, input logic [5:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, adr, 4'hF, wd};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        rd = wb_dat_o;
        check_word({31'h0, wb_ack_o}, 32'h1);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task automatic wb_read(input logic [3:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_xfer(1'h0, adr, 32'h0, d);
        check_word(d, exp);
    endtask
    task automatic wb_write(input logic [3:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        wb_xfer(1'h1, adr, wd, d);
    endtask
    // Expected results are worked out here when the instruction is issued
    task automatic send(input logic [10:0] f, input logic [31:0] raw, input logic [31:0] lim,
        input logic acc);
        logic def, op, ad, xf, ok;
        logic [31:0] eo, tp;
        @(posedge sys_clk);
        {issue, fld, rawR, limR} <= {1'h1, f, raw, lim};
        if (acc) begin
            def = (f[10:9] == MODE_PROT) && f[8];
            op = def ^ f[6];
            ad = def ^ f[5];
            xf = f[4] ? f[3] : op;
            eo = ad ? raw : {16'h0000, raw[15:0]};
            tp = f[0] ? TOP_WIDE : TOP_NARROW;
            ok = f[1] ? (eo > lim && eo <= tp) : (eo <= lim);
            lastF = {ok, xf, xf, f[2] ? f[7] : ad, ad, op};
            expF.push_back(lastF);
            expO.push_back(eo);
            expT.push_back(tp);
            nSent++;
            nPref += int'(f[6] | f[5]);
        end
    endtask
    task automatic drain;
        @(posedge sys_clk);
        issue <= 1'h0;
        repeat (4) @(posedge sys_clk);
        check_word(expF.size(), 32'h0);
    endtask
    always @(posedge sys_clk) begin
        if (resetn === 1'h1 && resValid !== 1'h0) begin
            if (expF.size() == 0)
                check_word({31'h0, resValid}, 32'h0);
            else begin
                check_flags(gotF, expF.pop_front());
                check_word(effOffset, expO.pop_front());
                check_word(expandTop, expT.pop_front());
            end
        end
    end

    // ======================================
    // Scenarios
    task automatic t_reset;
        check_flags(gotF, 6'h00);
        check_word(expandTop, TOP_NARROW);
        wb_read(REG_CTRL, 32'h1);
        wb_read(REG_COUNT, 32'h0);
        wb_read(4'h2, 32'h0);
    endtask
    task automatic t_modes;
        for (int k = 0; k < 32; k++)
            send({k[4:3], k[2], 1'h0, k[1:0], 5'h00}, 32'h00018001, 32'hFFFFFFFF, 1'h1);
        drain();
    endtask
    task automatic t_gate;
        for (int k = 0; k < 16; k++)
            send({MODE_PROT, k[3], 1'h0, k[2], 2'h1, k[1], 2'h0, k[0]}, 32'h10, 32'hFF, 1'h1);
        drain();
    endtask
    task automatic t_stack;
        for (int k = 0; k < 8; k++)
            send({MODE_PROT, 1'h0, k[2], 1'h0, k[1], 2'h0, k[0], 2'h0}, 32'h4, 32'h8, 1'h1);
        drain();
    endtask
    task automatic t_offset;
        logic [31:0] raws[7] = '{32'h00012345, 32'h2345, 32'h2345, 32'h2345, 32'h2345,
            32'h80000000, 32'h80000000};
        logic [31:0] lims[7] = '{32'hFFFFFFFF, 32'h2345, 32'h2344, 32'h2345, 32'h2344,
            32'h10, 32'h10};
        logic [2:0] md[7] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h7, 3'h6};
        for (int i = 0; i < 7; i++)
            send({MODE_REAL, 3'h0, md[i][2], 3'h0, md[i][1:0]}, raws[i], lims[i], 1'h1);
        drain();
    endtask
    task automatic t_ctrl;
        wb_read(REG_COUNT, nSent);
        wb_read(REG_OVRCOUNT, nPref);
        wb_read(REG_STATUS, {26'h0, lastF});
        wb_write(REG_CTRL, 32'h2);
        for (int k = 0; k < 3; k++)
            send(11'h1FF, 32'h5, 32'h9, 1'h0);
        drain();
        wb_read(REG_COUNT, 32'h0);
        wb_read(REG_OVRCOUNT, 32'h0);
        wb_write(REG_STATUS, 32'h3F);
        wb_write(4'h2, 32'h1);
        wb_read(REG_STATUS, {26'h0, lastF});
        wb_read(REG_CTRL, 32'h0);
        wb_write(REG_CTRL, 32'h1);
        send(11'h1FF, 32'h5, 32'h9, 1'h1);
        drain();
        wb_read(REG_COUNT, 32'h1);
        wb_read(REG_OVRCOUNT, 32'h1);
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'h1;
        @(posedge sys_clk);
        t_reset();
        t_modes();
        t_gate();
        t_stack();
        t_offset();
        t_ctrl();
        complete_run();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #400000;
        mismatches++;
        complete_run();
    end
endmodule
